/* rtl/ies_top.sv */
// Interrupt enable, pending summary and firmware base registers
//
// What this block does
// - Read-write enables for all interrupt sources
// - Read-write two-bit current privilege mode field
// - Trap requests need global and per-mode enable
// - Read-only summary shows enabled pending requests
// - Low perf bit counter zero, high one
// - One trap pending bit per privilege mode
// - Trap bit needs current mode at least mode
// - New hardware request during summary read returns zeros
// - Lost request resignalled on return to native
// - Base bits 43:15 writable, rest read zero
// - Base clears on reset, survives wake, fault
`timescale 1ns/1ps
`default_nettype none
`include "ies_params.svh"

module ies_top (
  input  wire logic                         sys_clk,
  input  wire logic                         reset_n,
  input  wire logic [`IES_ADDR_W-1:0]       reg_addr,
  input  wire logic [63:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [63:0]                  reg_rdata,
  input  wire logic [5:0]                   ext_irq_req,
  input  wire logic                         serial_line_req,
  input  wire logic                         corrected_read_err_req,
  input  wire logic [1:0]                   perf_counter_req,
  input  wire logic [15:1]                  software_irq_req,
  input  wire logic [3:0]                   per_mode_trap_enables,
  input  wire logic [3:0]                   per_mode_trap_requests,
  input  wire logic                         fault_reset,
  input  wire logic                         native_mode_return,
  output logic                              core_irq,
  output logic                              hw_irq_resignal,
  output logic      [1:0]                   current_privilege_mode
);

  ////////////////////////////////////////////////////////////////////////
  // State

  ies_pkg::ies_word_t enable_reg;
  ies_pkg::ies_word_t enable_next;
  ies_pkg::ies_word_t base_reg;
  ies_pkg::ies_word_t base_next;
  ies_pkg::ies_word_t rdata_reg;
  ies_pkg::ies_word_t rdata_next;
  logic [9:0]         hw_req_prev_reg;
  logic [9:0]         hw_req_prev_next;
  logic               lost_reg;
  logic               lost_next;
  logic               resignal_reg;
  logic               resignal_next;
  logic               core_irq_reg;
  logic               core_irq_next;

  ies_pkg::ies_word_t summary_word;
  logic [9:0]         hw_req_now;
  logic               new_hw_req;
  logic               summary_read;
  logic               collision;
  logic               wr_enable;
  logic               wr_base;

  ////////////////////////////////////////////////////////////////////////
  // Pending summary

  ies_summary_calc u_summary (
    .enable_word            (enable_reg),
    .ext_irq_req            (ext_irq_req),
    .serial_line_req        (serial_line_req),
    .corrected_read_err_req (corrected_read_err_req),
    .perf_counter_req       (perf_counter_req),
    .software_irq_req       (software_irq_req),
    .per_mode_trap_enables  (per_mode_trap_enables),
    .per_mode_trap_requests (per_mode_trap_requests),
    .summary_word           (summary_word)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode and collision detection

  always_comb begin
    hw_req_now   = {ext_irq_req, serial_line_req, corrected_read_err_req,
                    perf_counter_req};
    new_hw_req   = |(hw_req_now & ~hw_req_prev_reg);
    summary_read = reg_rd && (reg_addr == `IES_ADDR_SUMMARY);
    collision    = summary_read && new_hw_req;
    wr_enable    = reg_wr && (reg_addr == `IES_ADDR_ENABLE);
    wr_base      = reg_wr && (reg_addr == `IES_ADDR_BASE);
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable and mode register

  always_comb begin
    enable_next = enable_reg;
    if (fault_reset) begin
      enable_next = `IES_ENABLE_RST;
    end else if (wr_enable) begin
      enable_next = reg_wdata & `IES_ENABLE_WMASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      enable_reg <= `IES_ENABLE_RST;
    end else begin
      enable_reg <= enable_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Firmware base register, untouched by fault reset or wake-up

  always_comb begin
    base_next = base_reg;
    if (wr_base) begin
      base_next = reg_wdata & `IES_BASE_WMASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      base_reg <= `IES_BASE_RST;
    end else begin
      base_reg <= base_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe, zero otherwise

  always_comb begin
    rdata_next = 64'h0000_0000_0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `IES_ADDR_ENABLE:  rdata_next = enable_reg;
        `IES_ADDR_SUMMARY: begin
          rdata_next = collision ? 64'h0000_0000_0000_0000
                                 : summary_word;
        end
        `IES_ADDR_BASE:    rdata_next = base_reg;
        default:           rdata_next = 64'h0000_0000_0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdata_reg <= 64'h0000_0000_0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lost-request tracking and interrupt outputs

  always_comb begin
    hw_req_prev_next = hw_req_now;
    // A fresh collision wins over the clear by native return
    lost_next     = collision || (lost_reg && !native_mode_return);
    resignal_next = native_mode_return && lost_reg;
    core_irq_next = |summary_word;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      hw_req_prev_reg <= 10'h000;
      lost_reg        <= 1'b0;
      resignal_reg    <= 1'b0;
      core_irq_reg    <= 1'b0;
    end else begin
      hw_req_prev_reg <= hw_req_prev_next;
      lost_reg        <= lost_next;
      resignal_reg    <= resignal_next;
      core_irq_reg    <= core_irq_next;
    end
  end

  assign reg_rdata              = rdata_reg;
  assign core_irq               = core_irq_reg;
  assign hw_irq_resignal        = resignal_reg;
  assign current_privilege_mode = enable_reg[`IES_MODE_HI:`IES_MODE_LO];

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking ies_cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  a_enable_write: assert property (
    wr_enable && !fault_reset
    |=> enable_reg == ($past(reg_wdata) & `IES_ENABLE_WMASK))
    else $error("enable register did not take written value");

  a_mode_readback: assert property (
    wr_enable && !fault_reset ##1 reg_rd && reg_addr == `IES_ADDR_ENABLE
    |=> reg_rdata[`IES_MODE_HI:`IES_MODE_LO]
        == $past(reg_wdata[`IES_MODE_HI:`IES_MODE_LO], 2))
    else $error("mode field read back wrong");

  a_trap_gated: assert property (
    !enable_reg[`IES_TRAP_EN_BIT]
    |-> summary_word[`IES_USER_TRAP_BIT] == 1'b0
        && summary_word[`IES_SUPER_TRAP_BIT] == 1'b0
        && summary_word[`IES_EXEC_TRAP_BIT] == 1'b0
        && summary_word[`IES_KERN_TRAP_BIT] == 1'b0)
    else $error("trap pending without global trap enable");

  a_summary_read: assert property (
    summary_read && !collision |=> reg_rdata == $past(summary_word))
    else $error("summary read data mismatch");

  a_perf_map: assert property (
    summary_word[`IES_PERF_LO]
      == (perf_counter_req[0] && enable_reg[`IES_PERF_LO])
    && summary_word[`IES_PERF_HI]
      == (perf_counter_req[1] && enable_reg[`IES_PERF_HI]))
    else $error("performance counter summary bits swapped");

  a_kernel_trap: assert property (
    enable_reg[`IES_TRAP_EN_BIT] && per_mode_trap_enables[0]
    && per_mode_trap_requests[0] |-> summary_word[`IES_KERN_TRAP_BIT])
    else $error("kernel trap pending bit missing");

  a_trap_mode: assert property (
    enable_reg[`IES_MODE_HI:`IES_MODE_LO] == 2'h0
    |-> !summary_word[`IES_USER_TRAP_BIT]
        && !summary_word[`IES_SUPER_TRAP_BIT]
        && !summary_word[`IES_EXEC_TRAP_BIT])
    else $error("trap pending above kernel while in kernel mode");

  a_user_trap: assert property (
    enable_reg[`IES_MODE_HI:`IES_MODE_LO] == 2'h3
    && enable_reg[`IES_TRAP_EN_BIT] && per_mode_trap_enables[3]
    && per_mode_trap_requests[3] |-> summary_word[`IES_USER_TRAP_BIT])
    else $error("user trap not pending in user mode");

  a_collision_zero: assert property (
    summary_read && $rose(ext_irq_req[0])
    |=> reg_rdata == 64'h0000_0000_0000_0000)
    else $error("summary read not zeroed on new request");

  a_lost_resignal: assert property (
    lost_reg && native_mode_return |=> hw_irq_resignal)
    else $error("lost request not signalled again");

  a_base_reserved: assert property (
    (base_reg & ~`IES_BASE_WMASK) == 64'h0000_0000_0000_0000)
    else $error("reserved base bits not zero");

  a_base_fault_keep: assert property (
    fault_reset && !wr_base |=> $stable(base_reg))
    else $error("base register lost value on fault reset");

  a_base_reset: assert property (@(posedge sys_clk)
    disable iff (1'b0)
    !reset_n |=> base_reg == 64'h0000_0000_0000_0000)
    else $error("base register not cleared by reset");

  a_enable_reserved: assert property (
    (enable_reg & ~`IES_ENABLE_WMASK) == 64'h0000_0000_0000_0000)
    else $error("reserved enable bits set");

  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 64'h0000_0000_0000_0000)
    else $error("read data not zero outside read cycle");

  a_unmapped_read: assert property (
    reg_rd && reg_addr > `IES_ADDR_BASE
    |=> reg_rdata == 64'h0000_0000_0000_0000)
    else $error("unmapped read returned data");

  a_summary_reserved: assert property (
    (summary_word & ~`IES_SUMMARY_MASK) == 64'h0000_0000_0000_0000)
    else $error("reserved summary bits set");

  a_base_write: assert property (
    wr_base |=> base_reg == ($past(reg_wdata) & `IES_BASE_WMASK))
    else $error("base register did not take written value");

  a_resignal_cause: assert property (
    hw_irq_resignal |-> $past(lost_reg) && $past(native_mode_return))
    else $error("resignal without a lost request");

  a_irq_set: assert property (
    (|summary_word) |=> core_irq)
    else $error("interrupt output missing for pending request");

  a_irq_clear: assert property (
    !(|summary_word) |=> !core_irq)
    else $error("interrupt output without pending request");

  a_trap_exec_mode: assert property (
    enable_reg[`IES_MODE_HI:`IES_MODE_LO] == 2'h1
    |-> !summary_word[`IES_USER_TRAP_BIT]
        && !summary_word[`IES_SUPER_TRAP_BIT])
    else $error("trap pending above executive while in executive mode");

  a_trap_super_mode: assert property (
    enable_reg[`IES_MODE_HI:`IES_MODE_LO] == 2'h2
    |-> !summary_word[`IES_USER_TRAP_BIT])
    else $error("user trap pending while in supervisor mode");

  c_collision:   cover property (collision);
  c_resignal:    cover property (hw_irq_resignal);
  c_summary_hit: cover property (summary_read ##1 reg_rdata != 64'h0);
  c_user_trap:   cover property (summary_word[`IES_USER_TRAP_BIT]);
  c_fault_keep:  cover property (fault_reset && base_reg != 64'h0);

endmodule
`default_nettype wire

/* rtl/ies_params.svh */
// Offsets, field positions, masks and reset values of the interrupt block
`ifndef IES_PARAMS_SVH
`define IES_PARAMS_SVH

`define IES_ADDR_W          4
`define IES_ADDR_ENABLE     4'h0
`define IES_ADDR_SUMMARY    4'h1
`define IES_ADDR_BASE       4'h2

`define IES_EXT_HI          38
`define IES_EXT_LO          33
`define IES_SERIAL_BIT      32
`define IES_CRD_BIT         31
`define IES_PERF_HI         30
`define IES_PERF_LO         29
`define IES_SW_HI           28
`define IES_SW_LO           14
`define IES_TRAP_EN_BIT     13
`define IES_MODE_HI         4
`define IES_MODE_LO         3
`define IES_USER_TRAP_BIT   10
`define IES_SUPER_TRAP_BIT  9
`define IES_EXEC_TRAP_BIT   4
`define IES_KERN_TRAP_BIT   3

`define IES_ENABLE_WMASK    64'h0000_007F_FFFF_E018
`define IES_BASE_WMASK      64'h0000_0FFF_FFFF_8000
`define IES_SUMMARY_MASK    64'h0000_007F_FFFF_C618
`define IES_ENABLE_RST      64'h0000_0000_0000_0000
`define IES_BASE_RST        64'h0000_0000_0000_0000

`endif

/* rtl/ies_pkg.sv */
// Types shared by the interrupt enable and summary block
package ies_pkg;

  typedef logic [63:0] ies_word_t;

  typedef enum logic [1:0] {
    IES_KERNEL,
    IES_EXECUTIVE,
    IES_SUPERVISOR,
    IES_USER
  } ies_mode_e;

endpackage

/* rtl/ies_summary_calc.sv */
// Combinational pending summary word from enables and requests
`timescale 1ns/1ps
`default_nettype none
`include "ies_params.svh"

module ies_summary_calc (
  input  wire logic              [63:0] enable_word,
  input  wire logic              [5:0]  ext_irq_req,
  input  wire logic                     serial_line_req,
  input  wire logic                     corrected_read_err_req,
  input  wire logic              [1:0]  perf_counter_req,
  input  wire logic              [15:1] software_irq_req,
  input  wire logic              [3:0]  per_mode_trap_enables,
  input  wire logic              [3:0]  per_mode_trap_requests,
  output ies_pkg::ies_word_t            summary_word
);

  // Current mode at or above the given mode's encoding
  function automatic logic mode_at_least(input logic [1:0] cur,
                                         input ies_pkg::ies_mode_e m);
    mode_at_least = (cur >= m);
  endfunction

  // One trap bit: global enable, mode enable, mode request, mode check
  function automatic logic trap_pending(input logic [63:0] en,
                                        input logic [3:0] ten,
                                        input logic [3:0] treq,
                                        input ies_pkg::ies_mode_e m);
    trap_pending = en[`IES_TRAP_EN_BIT] & ten[m] & treq[m]
                 & mode_at_least(en[`IES_MODE_HI:`IES_MODE_LO], m);
  endfunction

  always_comb begin
    summary_word = 64'h0000_0000_0000_0000;
    summary_word[`IES_EXT_HI:`IES_EXT_LO] =
      ext_irq_req & enable_word[`IES_EXT_HI:`IES_EXT_LO];
    summary_word[`IES_SERIAL_BIT] =
      serial_line_req & enable_word[`IES_SERIAL_BIT];
    summary_word[`IES_CRD_BIT] =
      corrected_read_err_req & enable_word[`IES_CRD_BIT];
    // Lower bit is counter zero, upper bit counter one
    summary_word[`IES_PERF_HI:`IES_PERF_LO] =
      perf_counter_req & enable_word[`IES_PERF_HI:`IES_PERF_LO];
    summary_word[`IES_SW_HI:`IES_SW_LO] =
      software_irq_req & enable_word[`IES_SW_HI:`IES_SW_LO];
    summary_word[`IES_USER_TRAP_BIT] = trap_pending(enable_word,
      per_mode_trap_enables, per_mode_trap_requests, ies_pkg::IES_USER);
    summary_word[`IES_SUPER_TRAP_BIT] = trap_pending(enable_word,
      per_mode_trap_enables, per_mode_trap_requests,
      ies_pkg::IES_SUPERVISOR);
    summary_word[`IES_EXEC_TRAP_BIT] = trap_pending(enable_word,
      per_mode_trap_enables, per_mode_trap_requests,
      ies_pkg::IES_EXECUTIVE);
    summary_word[`IES_KERN_TRAP_BIT] = trap_pending(enable_word,
      per_mode_trap_enables, per_mode_trap_requests, ies_pkg::IES_KERNEL);
  end

endmodule
`default_nettype wire

/* verification/ies_top_bench.sv */
// Self-checking bench for the interrupt enable and summary block
`timescale 1ns/1ps
`default_nettype none

module ies_top_bench;
  localparam logic [63:0] EN_MASK   = 64'h0000_007F_FFFF_E018;
  localparam logic [63:0] BASE_MASK = 64'h0000_0FFF_FFFF_8000;

  logic        sys_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [63:0] reg_wdata = 64'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [63:0] reg_rdata;
  logic [5:0]  ext       = 6'h0;
  logic        ser       = 1'b0;
  logic        crd       = 1'b0;
  logic [1:0]  perf      = 2'h0;
  logic [15:1] sw        = 15'h0;
  logic [3:0]  ten       = 4'h0;
  logic [3:0]  treq      = 4'h0;
  logic        fault     = 1'b0;
  logic        native    = 1'b0;
  logic        core_irq;
  logic        resig;
  logic [1:0]  mode_out;
  logic [63:0] en_m      = 64'h0;
  logic [63:0] rnd;
  logic [63:0] wd;
  logic [63:0] exp_q [$];
  logic        rd_prev   = 1'b0;
  int          err_count   = 0;
  int          checks_done = 0;

  always #50 sys_clk = ~sys_clk;

  ies_top DUT (
    .sys_clk                (sys_clk),
    .reset_n                (reset_n),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_rdata              (reg_rdata),
    .ext_irq_req            (ext),
    .serial_line_req        (ser),
    .corrected_read_err_req (crd),
    .perf_counter_req       (perf),
    .software_irq_req       (sw),
    .per_mode_trap_enables  (ten),
    .per_mode_trap_requests (treq),
    .fault_reset            (fault),
    .native_mode_return     (native),
    .core_irq               (core_irq),
    .hw_irq_resignal        (resig),
    .current_privilege_mode (mode_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [63:0] seen,
                       input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Expected summary from the enable mirror and the request levels
  function automatic logic [63:0] sum_calc();
    logic [63:0] s;
    s = 64'h0;
    s[38:33] = ext & en_m[38:33];
    s[32]    = ser & en_m[32];
    s[31]    = crd & en_m[31];
    s[30:29] = perf & en_m[30:29];
    s[28:14] = sw & en_m[28:14];
    s[3]     = en_m[13] & ten[0] & treq[0];
    s[4]     = en_m[13] & ten[1] & treq[1] & (en_m[4:3] >= 2'h1);
    s[9]     = en_m[13] & ten[2] & treq[2] & (en_m[4:3] >= 2'h2);
    s[10]    = en_m[13] & ten[3] & treq[3] & (en_m[4:3] == 2'h3);
    return s;
  endfunction

  // One bus cycle; a read notes its expected data for the monitor
  task automatic acc(input logic w, input logic r, input logic [3:0] a,
                     input logic [63:0] d, input logic [63:0] e);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    if (r) begin
      exp_q.push_back(e);
    end
    @(posedge sys_clk);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    rd_prev <= reg_rd && reset_n;
  end

  // Looked at mid-cycle, where the registered data has settled
  always @(negedge sys_clk) begin
    if (rd_prev) begin
      check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    #(2000 * 100);
    err_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(13826));
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    acc(1'b0, 1'b1, 4'h0, 64'h0, 64'h0);
    acc(1'b0, 1'b1, 4'h2, 64'h0, 64'h0);
    acc(1'b1, 1'b0, 4'h0, '1, 64'h0);
    en_m = EN_MASK;
    acc(1'b0, 1'b1, 4'h0, 64'h0, EN_MASK);
    acc(1'b1, 1'b0, 4'h2, '1, 64'h0);
    acc(1'b0, 1'b1, 4'h2, 64'h0, BASE_MASK);
    acc(1'b1, 1'b0, 4'h1, '1, 64'h0);
    acc(1'b1, 1'b0, 4'hF, '1, 64'h0);
    acc(1'b0, 1'b1, 4'hF, 64'h0, 64'h0);
    acc(1'b0, 1'b1, 4'h1, 64'h0, sum_calc());
    // Random enables and request levels, modes stepped by the loop index, read after settling
    for (int i = 0; i < 32; i++) begin
      rnd = {$urandom, $urandom};
      wd  = {$urandom, $urandom};
      wd[4:3] = 2'(i);
      ext  <= rnd[5:0];
      ser  <= rnd[6];
      crd  <= rnd[7];
      perf <= rnd[9:8];
      sw   <= rnd[24:10];
      ten  <= rnd[28:25];
      treq <= rnd[32:29];
      acc(1'b1, 1'b0, 4'h0, wd, 64'h0);
      en_m = wd & EN_MASK;
      idle(1);
      acc(1'b0, 1'b1, 4'h1, '0, sum_calc());
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      check("mode", {62'h0, mode_out}, {62'h0, en_m[4:3]});
      check("core_irq", {63'h0, core_irq}, {63'h0, |sum_calc()});
      @(posedge sys_clk);
    end
    // New request rising in the read cycle, then the second read
    {ext, ser, crd, perf} <= 10'h0;
    acc(1'b1, 1'b0, 4'h0, EN_MASK, 64'h0);
    en_m = EN_MASK;
    idle(2);
    ext <= 6'h01;
    acc(1'b0, 1'b1, 4'h1, 64'h0, 64'h0);
    acc(1'b0, 1'b1, 4'h1, 64'h0, sum_calc());
    native <= 1'b1;
    idle(1);
    native <= 1'b0;
    @(negedge sys_clk);
    check("resignal", {63'h0, resig}, 64'h1);
    @(negedge sys_clk);
    check("resignal", {63'h0, resig}, 64'h0);
    @(posedge sys_clk);
    // Base survives a fault reset, clears on chip reset
    acc(1'b1, 1'b0, 4'h2, 64'hA5A5_A5A5_A5A5_A5A5, 64'h0);
    fault <= 1'b1;
    idle(1);
    fault <= 1'b0;
    acc(1'b0, 1'b1, 4'h2, '0, 64'hA5A5_A5A5_A5A5_A5A5 & BASE_MASK);
    reset_n <= 1'b0;
    idle(5);
    reset_n <= 1'b1;
    acc(1'b0, 1'b1, 4'h2, 64'h0, 64'h0);
    idle(3);
    print_verdict();
  end
endmodule

`default_nettype wire
